// [hw/pmes_latch_flag.sv]
// One latch-high flag that clears when its register is read.
// Assumes event and read strobe are synchronous to the core clock.
module pmes_latch_flag
  import pmes_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag_out
);

  // ==========================================================================
  // Flag storage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (event_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule

// [hw/pmes_regs.sv]
// Transceiver mode control, event status and event enable registers.
// Assumes event inputs are one-cycle or level strobes from negotiation logic.
//
// Local design decision: the plain strobed port.
module pmes_regs
  import pmes_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic pause_on_in,
  input wire logic neg_done_in,
  input wire logic remote_fault_in,
  input wire logic link_down_in,
  input wire logic code_word_rx_in,
  input wire logic pdet_fault_in,
  input wire logic page_rx_in,
  input wire logic rx_err_pkt_in,
  output logic long_cable_squelch_out,
  output logic irq_out
);

  logic long_cable_squelch;
  logic [6:0] event_enable_reg;
  logic [6:0] flags;
  logic [6:0] events;
  logic [6:0] rx_err_count;
  logic rx_err_full;
  logic status_read;

  // ==========================================================================
  // Address decode
  function automatic logic pmes_hit(input logic [7:0] a, input logic [7:0] off);
    pmes_hit = (a == off);
  endfunction

  assign status_read = rd_in && pmes_hit(addr_in, PMES_EVENT_STATUS_OFFSET);

  // ==========================================================================
  // Writable registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      long_cable_squelch <= 1'b0;
    end else if (wr_in && pmes_hit(addr_in, PMES_MODE_CTRL_OFFSET)) begin
      long_cable_squelch <= wdata_in[PMES_LONG_CABLE_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      event_enable_reg <= PMES_FLAGS_RESET;
    end else if (wr_in && pmes_hit(addr_in, PMES_EVENT_ENABLE_OFFSET)) begin
      event_enable_reg <= wdata_in[6:0];
    end
  end

  assign long_cable_squelch_out = long_cable_squelch;

  // ==========================================================================
  // Receive error counter
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_err_count <= 7'h00;
    end else if (status_read && rx_err_full) begin
      rx_err_count <= 7'h00;
    end else if (rx_err_pkt_in && rx_err_count < PMES_RX_ERR_LIMIT) begin
      rx_err_count <= rx_err_count + 7'h01;
    end
  end

  assign rx_err_full = (rx_err_count >= PMES_RX_ERR_LIMIT);

  // ==========================================================================
  // Latched event flags
  assign events = {neg_done_in,
                   remote_fault_in,
                   link_down_in,
                   code_word_rx_in,
                   pdet_fault_in,
                   page_rx_in,
                   rx_err_full};

  for (genvar i = 0; i < PMES_NUM_EVENTS; i++) begin : g_flag
    pmes_latch_flag u_flag (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .event_in(events[i]),
      .clear_in(status_read),
      .flag_out(flags[i])
    );
  end

  // ==========================================================================
  // Read data and interrupt
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_out <= PMES_REG_RESET;
    end else if (rd_in) begin
      rdata_out <= PMES_REG_RESET;
      if (pmes_hit(addr_in, PMES_MODE_CTRL_OFFSET)) begin
        rdata_out[PMES_LONG_CABLE_BIT] <= long_cable_squelch;
      end else if (status_read) begin
        rdata_out[PMES_SPEED_BIT] <= speed_100_in;
        rdata_out[PMES_DUPLEX_BIT] <= full_duplex_in;
        rdata_out[PMES_PAUSE_BIT] <= pause_on_in;
        rdata_out[6:0] <= flags;
      end else if (pmes_hit(addr_in, PMES_EVENT_ENABLE_OFFSET)) begin
        rdata_out[6:0] <= event_enable_reg;
      end
    end else begin
      rdata_out <= PMES_REG_RESET;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flags & event_enable_reg);
    end
  end

endmodule

// [pkg/pmes_pkg.sv]
// Package for the transceiver mode and event status register bank.
// Assumes a 100 MHz core clock and a plain register port with byte offsets.
package pmes_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] PMES_MODE_CTRL_OFFSET = 8'hd0;
  localparam logic [7:0] PMES_EVENT_STATUS_OFFSET = 8'hd4;
  localparam logic [7:0] PMES_EVENT_ENABLE_OFFSET = 8'hd8;

  // ==========================================================================
  // Field positions
  localparam int PMES_LONG_CABLE_BIT = 11;
  localparam int PMES_SPEED_BIT = 9;
  localparam int PMES_DUPLEX_BIT = 8;
  localparam int PMES_PAUSE_BIT = 7;
  localparam int PMES_NEG_DONE_BIT = 6;
  localparam int PMES_REMOTE_FAULT_BIT = 5;
  localparam int PMES_LINK_DOWN_BIT = 4;
  localparam int PMES_CODE_WORD_BIT = 3;
  localparam int PMES_PDET_FAULT_BIT = 2;
  localparam int PMES_PAGE_RX_BIT = 1;
  localparam int PMES_RX_ERR_FULL_BIT = 0;
  localparam int PMES_NUM_EVENTS = 7;

  // ==========================================================================
  // Reset values and counts
  localparam logic [15:0] PMES_REG_RESET = 16'h0000;
  localparam logic [6:0] PMES_FLAGS_RESET = 7'h00;
  localparam logic [6:0] PMES_RX_ERR_LIMIT = 7'h40;

endpackage

// [testbench/pmes_regs_asserts.sv]
// Checker for the mode and event status register bank.
// Assumes it is bound to pmes_regs and sees only its ports.
module pmes_regs_asserts
  import pmes_pkg::*;
(
  input wire logic core_clk_in, rst_in, wr_in, rd_in, irq_out,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in, rdata_out,
  input wire logic speed_100_in, full_duplex_in, pause_on_in,
  input wire logic neg_done_in, page_rx_in, long_cable_squelch_out
);
  // ==========================================================================
  // Properties
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire logic rs = rd_in && addr_in == 8'hd4;
  wire logic um = addr_in != 8'hd0 && addr_in != 8'hd4 && addr_in != 8'hd8;
  property p_lc;
    wr_in && addr_in == 8'hd0 |=> long_cable_squelch_out == $past(wdata_in[11]);
  endproperty
  property p_md;
    rd_in && addr_in == 8'hd0 |=> rdata_out == {4'h0, $past(long_cable_squelch_out), 11'h000};
  endproperty
  property p_st;
    rs |=> rdata_out[15:7] == {6'h00, $past(speed_100_in), $past(full_duplex_in), $past(pause_on_in)};
  endproperty
  property p_um;
    rd_in && um |=> rdata_out == 16'h0000;
  endproperty
  property p_set;
    neg_done_in ##1 !rd_in ##1 rs |=> rdata_out[6];
  endproperty
  property p_clr;
    rs && !neg_done_in ##1 !neg_done_in ##1 rs && !neg_done_in |=> !rdata_out[6];
  endproperty
  property p_keep;
    rs && page_rx_in ##1 !rs ##1 rs |=> rdata_out[1];
  endproperty
  property p_irq;
    wr_in && addr_in == 8'hd8 && wdata_in[6:0] == 7'h00 |=> ##1 !irq_out;
  endproperty
  a_lc: assert property (p_lc) else $error("long cable bit wrong");
  a_md: assert property (p_md) else $error("mode read wrong");
  a_st: assert property (p_st) else $error("status read wrong");
  a_um: assert property (p_um) else $error("unmapped read not zero");
  a_set: assert property (p_set) else $error("flag not latched");
  a_clr: assert property (p_clr) else $error("flag not cleared");
  a_keep: assert property (p_keep) else $error("event lost at read");
  a_irq: assert property (p_irq) else $error("masked irq high");
  cover property (rs ##1 rdata_out[6]);
  cover property (irq_out);
  cover property (wr_in && addr_in == 8'hd0 && wdata_in[11]);
endmodule
bind pmes_regs pmes_regs_asserts u_chk (.core_clk_in, .rst_in, .wr_in, .rd_in, .irq_out,
  .addr_in, .wdata_in, .rdata_out, .speed_100_in, .full_duplex_in, .pause_on_in,
  .neg_done_in, .page_rx_in, .long_cable_squelch_out);

// [testbench/pmes_regs_test.sv]
// Self-checking bench for the register bank.
// Assumes pmes_regs with its checker bound in.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module pmes_regs_test import pmes_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Stimulus
  logic clk = 0, rst = 1, wr = 0, rd = 0, sp = 1, du = 0, pa = 1;
  logic [7:0] ad = 8'h00;
  logic [15:0] wd = 16'h0000, rdat, d;
  logic [6:0] ev = 7'h00;
  logic lc, irq;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  pmes_regs uut (.core_clk_in(clk), .rst_in(rst), .addr_in(ad), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdat), .speed_100_in(sp), .full_duplex_in(du), .pause_on_in(pa),
    .neg_done_in(ev[6]), .remote_fault_in(ev[5]), .link_down_in(ev[4]),
    .code_word_rx_in(ev[3]), .pdet_fault_in(ev[2]), .page_rx_in(ev[1]),
    .rx_err_pkt_in(ev[0]), .long_cable_squelch_out(lc), .irq_out(irq));
  task results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wrt(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk); ad <= a; wd <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rdt(input logic [7:0] a);
    @(posedge clk); ad <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdat;
  endtask
  task pulse(input int i);
    @(posedge clk); ev[i] <= 1'b1;
    @(posedge clk); ev[i] <= 1'b0;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin num_errors++; results; end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdt(8'hd0); `CHK(d, 16'h0000)
    wrt(8'hd0, 16'hffff); rdt(8'hd0); `CHK(d, 16'h0800)
    `CHK(lc, 1'b1)
    wrt(8'hd0, 16'h0000); rdt(8'hd0); `CHK(lc, 1'b0)
    wrt(8'hd4, 16'hffff); rdt(8'hd4); `CHK(d, 16'h0280)
    @(posedge clk); sp <= 1'b0; du <= 1'b1; pa <= 1'b0;
    for (int i = 1; i < 7; i++) begin
      pulse(i); rdt(8'hd4); `CHK(d, 16'h0100 | (16'h0001 << i))
      rdt(8'hd4); `CHK(d, 16'h0100)
    end
    repeat (63) pulse(0);
    rdt(8'hd4); `CHK(d, 16'h0100)
    pulse(0); rdt(8'hd4); `CHK(d, 16'h0101)
    wrt(8'hd8, 16'hffff); rdt(8'hd8); `CHK(d, 16'h007f)
    wrt(8'hd8, 16'h0020); rdt(8'hd4); pulse(5); repeat (2) @(posedge clk); `CHK(irq, 1'b1)
    wrt(8'hd8, 16'h0000); repeat (2) @(posedge clk); `CHK(irq, 1'b0)
    wrt(8'hd8, 16'h0020); repeat (2) @(posedge clk); `CHK(irq, 1'b1)
    rdt(8'hd4); repeat (2) @(posedge clk); `CHK(irq, 1'b0)
    @(posedge clk); ev[1] <= 1'b1; ad <= 8'hd4; rd <= 1'b1;
    @(posedge clk); ev[1] <= 1'b0; rd <= 1'b0;
    rdt(8'hd4); `CHK(d[1], 1'b1)
    wrt(8'h10, 16'hffff); rdt(8'h10); `CHK(d, 16'h0000)
    results;
  end
endmodule
